// [design/hpl_map.vh]
// Constants for the host packet link: framing, classes, timing.
// Assumes inclusion by bare name from the design files.
`ifndef HPL_MAP_VH
`define HPL_MAP_VH
`define HPL_CLK_HZ        25000000
`define HPL_BAUD_SLOW     19200
`define HPL_BAUD_FAST     115200
`define HPL_MAX_LEN       8'h12
`define HPL_CLS_CMD       2'b00
`define HPL_CLS_RSP       2'b01
`define HPL_CLS_RPT       2'b10
`define HPL_CLS_ERR       2'b11
`define HPL_CRC_INIT      16'hFFFF
`define HPL_CRC_POLY      16'h8408
`define HPL_DEADLINE_MS   250
`define HPL_DEADLINE_CYC  (`HPL_CLK_HZ / 1000 * `HPL_DEADLINE_MS)
`define HPL_BIT_SLOW_CYC  (`HPL_CLK_HZ / `HPL_BAUD_SLOW)
`define HPL_BIT_FAST_CYC  (`HPL_CLK_HZ / `HPL_BAUD_FAST)
`endif

// [design/hpl_uart.v]
// Serial character engine: 8 data bits, no parity, one stop bit.
// Assumes rx_i is already synchronised and bit_cyc_i is stable between characters.
`include "hpl_map.vh"
module hpl_uart #(
  parameter CW = 16
) (
  input  wire          clk_i,
  input  wire          rst_n_i,
  input  wire [CW-1:0] bit_cyc_i,
  input  wire          rx_i,
  output reg           rx_stb_o,
  output reg  [7:0]    rx_data_o,
  input  wire          tx_go_i,
  input  wire [7:0]    tx_data_i,
  output wire          tx_busy_o,
  output reg           tx_o
);
  // =====================================================
  // Receiver
  reg [CW-1:0] rcnt_ff;
  reg [3:0]    rbit_ff;
  reg          ract_ff;
  reg [7:0]    rsh_ff;
  // Samples mid-bit; a false start (low glitch) is dropped at the half point
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rcnt_ff   <= {CW{1'b0}};
      rbit_ff   <= 4'h0;
      ract_ff   <= 1'b0;
      rsh_ff    <= 8'h00;
      rx_stb_o  <= 1'b0;
      rx_data_o <= 8'h00;
    end else begin
      rx_stb_o <= 1'b0;
      if (!ract_ff) begin
        if (!rx_i) begin
          ract_ff <= 1'b1;
          rcnt_ff <= bit_cyc_i >> 1;
          rbit_ff <= 4'h0;
        end
      end else if (rcnt_ff != {CW{1'b0}}) begin
        rcnt_ff <= rcnt_ff - 1'b1;
      end else begin
        rcnt_ff <= bit_cyc_i - 1'b1;
        rbit_ff <= rbit_ff + 4'h1;
        if (rbit_ff == 4'h0) begin
          if (rx_i) ract_ff <= 1'b0;
        end else if (rbit_ff == 4'h9) begin
          ract_ff <= 1'b0;
          if (rx_i) begin
            rx_stb_o  <= 1'b1;
            rx_data_o <= rsh_ff;
          end
        end else begin
          rsh_ff <= {rx_i, rsh_ff[7:1]};
        end
      end
    end
  end

  // =====================================================
  // Transmitter
  reg [CW-1:0] tcnt_ff;
  reg [3:0]    tbit_ff;
  reg          tact_ff;
  reg [8:0]    tsh_ff;
  assign tx_busy_o = tact_ff;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tcnt_ff <= {CW{1'b0}};
      tbit_ff <= 4'h0;
      tact_ff <= 1'b0;
      tsh_ff  <= 9'h1FF;
      tx_o    <= 1'b1;
    end else if (!tact_ff) begin
      tx_o <= 1'b1;
      if (tx_go_i) begin
        tact_ff <= 1'b1;
        tx_o    <= 1'b0;
        tsh_ff  <= {1'b1, tx_data_i};
        tcnt_ff <= bit_cyc_i - 1'b1;
        tbit_ff <= 4'h0;
      end
    end else if (tcnt_ff != {CW{1'b0}}) begin
      tcnt_ff <= tcnt_ff - 1'b1;
    end else if (tbit_ff == 4'h9) begin
      tact_ff <= 1'b0;
      tx_o    <= 1'b1;
    end else begin
      tcnt_ff <= bit_cyc_i - 1'b1;
      tbit_ff <= tbit_ff + 4'h1;
      tx_o    <= tsh_ff[0];
      tsh_ff  <= {1'b1, tsh_ff[8:1]};
    end
  end
endmodule // hpl_uart

// [design/hpl_link.v]
// Packet layer of the host serial link: receives, checks and sends packets.
// Assumes the command logic answers each delivered packet through the reply port.
`include "hpl_map.vh"
module hpl_link #(
  parameter DEADLINE_CYC = `HPL_DEADLINE_CYC,
  parameter MAXLEN       = 18
) (
  input  wire        clk_i,
  input  wire        rstn_i,
  input  wire        rx_i,
  output reg         tx_o,
  input  wire        fast_baud_i,
  output reg         cmd_stb_o,
  output reg  [5:0]  cmd_code_o,
  output reg  [4:0]  cmd_len_o,
  output reg  [7:0]  cmd_byte_o,
  output reg         cmd_byte_stb_o,
  output reg  [4:0]  cmd_byte_idx_o,
  output reg         pend_o,
  output reg         late_o,
  input  wire        pkt_go_i,
  input  wire [1:0]  pkt_cls_i,
  input  wire [5:0]  pkt_code_i,
  input  wire [4:0]  pkt_len_i,
  input  wire [7:0]  pkt_byte_i,
  output reg         pkt_byte_req_o,
  output reg  [4:0]  pkt_byte_idx_o,
  output reg         pkt_busy_o
);
  // =====================================================
  // Reset release and input synchroniser
  reg rst_a_ff, rst_b_ff, rx_a_ff, rx_b_ff;
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_a_ff <= 1'b0;
      rst_b_ff <= 1'b0;
    end else begin
      rst_a_ff <= 1'b1;
      rst_b_ff <= rst_a_ff;
    end
  end
  wire rst_n = rst_b_ff;
  // Idle line is high; the sync resets to idle so no false start bit
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_a_ff <= 1'b1;
      rx_b_ff <= 1'b1;
    end else begin
      rx_a_ff <= rx_i;
      rx_b_ff <= rx_a_ff;
    end
  end

  // =====================================================
  // Rate select: reset gives the slow rate
  reg baud_fast_ff;
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) baud_fast_ff <= 1'b0;
    else        baud_fast_ff <= fast_baud_i;
  end
  localparam integer SLOW_INT = `HPL_BIT_SLOW_CYC, FAST_INT = `HPL_BIT_FAST_CYC;
  localparam [15:0]  SLOW_CYC = SLOW_INT[15:0], FAST_CYC = FAST_INT[15:0];
  // Rate only changes the bit time; framing stays 8N1 and no flow control exists
  wire [15:0] bit_cyc = baud_fast_ff ? FAST_CYC : SLOW_CYC;

  wire       rx_stb;
  wire [7:0] rx_data;
  reg        tx_go_ff;
  reg  [7:0] tx_data_ff;
  wire       tx_busy;
  wire       tx_w;
  hpl_uart #(.CW(16)) u_uart (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n),
    .bit_cyc_i (bit_cyc),
    .rx_i      (rx_b_ff),
    .rx_stb_o  (rx_stb),
    .rx_data_o (rx_data),
    .tx_go_i   (tx_go_ff),
    .tx_data_i (tx_data_ff),
    .tx_busy_o (tx_busy),
    .tx_o      (tx_w)
  );
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) tx_o <= 1'b1;
    else        tx_o <= tx_w;
  end

  // =====================================================
  // CRC step, reflected 16-bit, one byte per call
  function [15:0] crc_byte;
    input [15:0] c;
    input [7:0]  d;
    integer      k;
    reg   [15:0] r;
    begin
      r = c ^ {8'h00, d};
      for (k = 0; k < 8; k = k + 1)
        r = r[0] ? ((r >> 1) ^ `HPL_CRC_POLY) : (r >> 1);
      crc_byte = r;
    end
  endfunction

  // =====================================================
  // Receive state machine
  localparam [4:0] R_TYPE = 5'h01, R_LEN = 5'h02, R_DATA = 5'h04,
                   R_CLO  = 5'h08, R_CHI = 5'h10;
  reg [4:0]  rst_ff;
  reg [15:0] rcrc_ff;
  reg [7:0]  rtype_ff, rclo_ff;
  reg [4:0]  rlen_ff, ridx_ff;
  reg [31:0] rtmo_ff;
  // Payload is delivered byte by byte as it arrives; commit only on good CRC.
  // Trade-off: no packet buffer, so the user must discard on a missing cmd_stb_o.
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rst_ff <= R_TYPE;
      rcrc_ff <= `HPL_CRC_INIT;
      rtype_ff <= 8'h00;
      rclo_ff <= 8'h00;
      rlen_ff <= 5'h00;
      ridx_ff <= 5'h00;
      rtmo_ff <= 32'h0000_0000;
      cmd_stb_o <= 1'b0;
      cmd_code_o <= 6'h00;
      cmd_len_o <= 5'h00;
      cmd_byte_o <= 8'h00;
      cmd_byte_stb_o <= 1'b0;
      cmd_byte_idx_o <= 5'h00;
    end else begin
      cmd_stb_o <= 1'b0;
      cmd_byte_stb_o <= 1'b0;
      if (rst_ff != R_TYPE)
        rtmo_ff <= rtmo_ff + 32'h0000_0001;
      if (rst_ff != R_TYPE && rtmo_ff >= DEADLINE_CYC - 1) begin
        rst_ff <= R_TYPE;
      end else if (rx_stb) begin
        case (rst_ff)
          R_TYPE: begin
            // Only commands are accepted inbound; other classes are noise
            if (rx_data[7:6] == `HPL_CLS_CMD) begin
              rtype_ff <= rx_data;
              rcrc_ff <= crc_byte(`HPL_CRC_INIT, rx_data);
              rtmo_ff <= 32'h0000_0000;
              rst_ff <= R_LEN;
            end
          end
          R_LEN: begin
            if (rx_data > MAXLEN) begin
              rst_ff <= R_TYPE;
            end else begin
              rlen_ff <= rx_data[4:0];
              ridx_ff <= 5'h00;
              rcrc_ff <= crc_byte(rcrc_ff, rx_data);
              rst_ff <= (rx_data == 8'h00) ? R_CLO : R_DATA;
            end
          end
          R_DATA: begin
            cmd_byte_o <= rx_data;
            cmd_byte_idx_o <= ridx_ff;
            cmd_byte_stb_o <= 1'b1;
            rcrc_ff <= crc_byte(rcrc_ff, rx_data);
            ridx_ff <= ridx_ff + 5'h01;
            if (ridx_ff + 5'h01 == rlen_ff) rst_ff <= R_CLO;
          end
          R_CLO: begin
            rclo_ff <= rx_data;
            rst_ff <= R_CHI;
          end
          R_CHI: begin
            rst_ff <= R_TYPE;
            if ({rx_data, rclo_ff} == rcrc_ff) begin
              cmd_stb_o <= 1'b1;
              cmd_code_o <= rtype_ff[5:0];
              cmd_len_o <= rlen_ff;
            end
          end
          default: rst_ff <= R_TYPE;
        endcase
      end
    end
  end

  // =====================================================
  // Answer deadline watch: pending from a good packet until a reply starts
  reg [31:0] ack_cnt_ff;
  wire reply_go = pkt_go_i && !pkt_busy_o && (pkt_cls_i == `HPL_CLS_RSP ||
                  pkt_cls_i == `HPL_CLS_ERR) && pkt_code_i == cmd_code_o;
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pend_o <= 1'b0;
      late_o <= 1'b0;
      ack_cnt_ff <= 32'h0000_0000;
    end else if (cmd_stb_o) begin
      pend_o <= 1'b1;  // New packet wins over a reply starting the same cycle
      late_o <= 1'b0;
      ack_cnt_ff <= 32'h0000_0000;
    end else if (reply_go) begin
      pend_o <= 1'b0;
    end else if (pend_o) begin
      ack_cnt_ff <= ack_cnt_ff + 32'h0000_0001;
      if (ack_cnt_ff >= DEADLINE_CYC - 1) late_o <= 1'b1;
    end
  end

  // =====================================================
  // Transmit state machine: type, length, payload, CRC low then high
  localparam [4:0] T_IDLE = 5'h01, T_HDR = 5'h02, T_DATA = 5'h04,
                   T_CLO  = 5'h08, T_CHI = 5'h10;
  reg [4:0]  tst_ff;
  reg [15:0] tcrc_ff;
  reg [4:0]  tlen_ff;
  always @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tst_ff <= T_IDLE;
      tcrc_ff <= `HPL_CRC_INIT;
      tlen_ff <= 5'h00;
      tx_go_ff <= 1'b0;
      tx_data_ff <= 8'h00;
      pkt_byte_req_o <= 1'b0;
      pkt_byte_idx_o <= 5'h00;
      pkt_busy_o <= 1'b0;
    end else begin
      tx_go_ff <= 1'b0;
      pkt_byte_req_o <= 1'b0;
      case (tst_ff)
        T_IDLE: begin
          // Over-long requests are clipped so no illegal length goes out
          if (pkt_go_i && !pkt_busy_o && pkt_cls_i != `HPL_CLS_CMD) begin
            tlen_ff <= (pkt_len_i > MAXLEN) ? MAXLEN[4:0] : pkt_len_i;
            tx_data_ff <= {pkt_cls_i, pkt_code_i};
            tcrc_ff <= crc_byte(`HPL_CRC_INIT, {pkt_cls_i, pkt_code_i});
            tx_go_ff <= 1'b1;
            pkt_busy_o <= 1'b1;
            tst_ff <= T_HDR;
          end else begin // Busy holds until the last character has left, so no header is lost
            pkt_busy_o <= tx_busy || tx_go_ff;
          end
        end
        T_HDR: begin
          if (!tx_busy && !tx_go_ff) begin
            tx_data_ff <= {3'b000, tlen_ff};
            tcrc_ff <= crc_byte(tcrc_ff, {3'b000, tlen_ff});
            tx_go_ff <= 1'b1;
            pkt_byte_idx_o <= 5'h00;
            pkt_byte_req_o <= (tlen_ff != 5'h00);
            tst_ff <= (tlen_ff == 5'h00) ? T_CLO : T_DATA;
          end
        end
        T_DATA: begin
          // Payload byte must stay valid on pkt_byte_i from the request until the previous character has left
          if (!tx_busy && !tx_go_ff && !pkt_byte_req_o) begin
            tx_data_ff <= pkt_byte_i;
            tcrc_ff <= crc_byte(tcrc_ff, pkt_byte_i);
            tx_go_ff <= 1'b1;
            if (pkt_byte_idx_o + 5'h01 == tlen_ff) begin
              tst_ff <= T_CLO;
            end else begin
              pkt_byte_idx_o <= pkt_byte_idx_o + 5'h01;
              pkt_byte_req_o <= 1'b1;
            end
          end
        end
        T_CLO: begin
          if (!tx_busy && !tx_go_ff) begin
            tx_data_ff <= tcrc_ff[7:0];
            tx_go_ff <= 1'b1;
            tst_ff <= T_CHI;
          end
        end
        T_CHI: begin
          if (!tx_busy && !tx_go_ff) begin
            tx_data_ff <= tcrc_ff[15:8];
            tx_go_ff <= 1'b1;
            tst_ff <= T_IDLE;
          end
        end
        default: tst_ff <= T_IDLE;
      endcase
    end
  end
endmodule // hpl_link

// [tb/hpl_link_chk.sv]
// Port checker for the host packet link.
// Bound to hpl_link by the bench; sees only that module's ports.
module hpl_link_chk #(
  parameter int DEADLINE_CYC = 14000
) (
  input wire logic       clk_i,
  input wire logic       rstn_i,
  input wire logic       tx_o,
  input wire logic       cmd_stb_o,
  input wire logic [5:0] cmd_code_o,
  input wire logic [4:0] cmd_len_o,
  input wire logic       pend_o,
  input wire logic       late_o,
  input wire logic       pkt_go_i,
  input wire logic [1:0] pkt_cls_i,
  input wire logic [5:0] pkt_code_i,
  input wire logic       pkt_busy_o,
  input wire logic       pkt_byte_req_o,
  input wire logic [4:0] pkt_byte_idx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] pend_cnt_ff;
  wire         go_ok = pkt_go_i && !pkt_busy_o;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // ==========
  // Age of the unanswered packet, to time the late flag
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) pend_cnt_ff <= '0;
    else pend_cnt_ff <= pend_o ? pend_cnt_ff + 1 : '0;
  end
  property p_go_busy; go_ok && pkt_cls_i != 2'b00 |=> pkt_busy_o; endproperty
  a_go_busy: assert property (p_go_busy) else $error("busy missing");
  property p_go_start; go_ok && pkt_cls_i != 2'b00 |-> ##[1:3] $fell(tx_o); endproperty
  a_go_start: assert property (p_go_start) else $error("no start bit");
  property p_cmd_cls; go_ok && pkt_cls_i == 2'b00 |=> !pkt_busy_o [*2]; endproperty
  a_cmd_cls: assert property (p_cmd_cls) else $error("command class sent");
  property p_stb_pend; cmd_stb_o |-> ##[0:1] pend_o; endproperty
  a_stb_pend: assert property (p_stb_pend) else $error("pend not set");
  property p_stb_late; cmd_stb_o |=> !late_o; endproperty
  a_stb_late: assert property (p_stb_late) else $error("late not cleared");
  property p_len_max; cmd_stb_o |-> cmd_len_o <= 5'd18; endproperty
  a_len_max: assert property (p_len_max) else $error("length over limit");
  property p_req; pkt_byte_req_o |-> pkt_busy_o && pkt_byte_idx_o < 5'd18; endproperty
  a_req: assert property (p_req) else $error("bad byte request");
  property p_late; $rose(late_o) |-> pend_o && pend_cnt_ff + 2 >= DEADLINE_CYC
    && pend_cnt_ff <= DEADLINE_CYC + 2; endproperty
  a_late: assert property (p_late) else $error("late flag mistimed");
  property p_clr; go_ok && pend_o && !cmd_stb_o && pkt_cls_i[0] && pkt_code_i == cmd_code_o
    |-> ##[1:2] !pend_o; endproperty
  a_clr: assert property (p_clr) else $error("reply left pend");
endmodule // hpl_link_chk

// [tb/hpl_host_model.sv]
// Host computer model: 8N1 sender and receiver at the selected rate.
// Assumes its tasks are called at falling clock edges.
module hpl_host_model (
  input  wire logic clk_i,
  input  wire logic fast_i,
  input  wire logic tx_i,
  output logic      rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SLOW_BIT = 25000000 / 19200;
  localparam int FAST_BIT = 25000000 / 115200;
  int         bc;
  logic [7:0] rx_b;
  logic [7:0] rxq[$];
  assign bc = fast_i ? FAST_BIT : SLOW_BIT;
  // Line idles high; there are no handshake lines at all
  initial rx_o = 1'b1;
  // ==========
  // Reflected CRC, low bit first
  function automatic logic [15:0] crc_upd(input logic [15:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ d[i]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
    end
    return c;
  endfunction
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      rx_o = f[i];
      repeat (bc) @(negedge clk_i);
    end
  endtask
  // Bad packets carry an all-ones check value, which also fails resync
  task automatic send_pkt(input logic [7:0] t, l, d, input logic bad);
    logic [15:0] c;
    c = crc_upd(crc_upd(16'hffff, t), l);
    send_byte(t);
    send_byte(l);
    if (l != 8'h00) begin
      c = crc_upd(c, d);
      send_byte(d);
    end
    if (bad) c = 16'hffff;
    send_byte(c[7:0]);
    send_byte(c[15:8]);
  endtask
  // Receiver samples mid-bit and queues every character
  always begin
    @(negedge clk_i);
    if (tx_i === 1'b0) begin
      repeat (bc / 2) @(negedge clk_i);
      for (int i = 0; i < 8; i++) begin
        repeat (bc) @(negedge clk_i);
        rx_b[i] = tx_i;
      end
      repeat (bc) @(negedge clk_i);
      rxq.push_back(rx_b);
    end
  end
endmodule // hpl_host_model

// [tb/tb_hpl_link.sv]
// Bench for the host packet link; replies are driven here.
// Assumes the checker and the host model are compiled first.
module tb_hpl_link;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DL = 12000;
  logic       clk_i = 1'b0;
  logic       rstn_i = 1'b0;
  logic       fast_baud_i = 1'b0;
  logic       pkt_go_i = 1'b0;
  logic [1:0] pkt_cls_i = 2'b00;
  logic [5:0] pkt_code_i = 6'h00;
  logic [4:0] pkt_len_i = 5'h00;
  logic [7:0] pkt_byte_i = 8'h3c;
  logic       rx_w, tx_o, cmd_stb_o, cmd_byte_stb_o, pend_o, late_o, pkt_byte_req_o, pkt_busy_o;
  logic [5:0] cmd_code_o;
  logic [4:0] cmd_len_o, cmd_byte_idx_o, pkt_byte_idx_o;
  logic [7:0] cmd_byte_o;
  logic [7:0] pay_q[$];
  int         mismatches = 0, total_checks = 0, cyc = 0, n_cmd = 0;
  always #20 clk_i = ~clk_i;
  hpl_link #(.DEADLINE_CYC(DL)) dut (
    .clk_i(clk_i), .rstn_i(rstn_i), .rx_i(rx_w), .tx_o(tx_o), .fast_baud_i(fast_baud_i),
    .cmd_stb_o(cmd_stb_o), .cmd_code_o(cmd_code_o), .cmd_len_o(cmd_len_o),
    .cmd_byte_o(cmd_byte_o), .cmd_byte_stb_o(cmd_byte_stb_o), .cmd_byte_idx_o(cmd_byte_idx_o),
    .pend_o(pend_o), .late_o(late_o), .pkt_go_i(pkt_go_i), .pkt_cls_i(pkt_cls_i),
    .pkt_code_i(pkt_code_i), .pkt_len_i(pkt_len_i), .pkt_byte_i(pkt_byte_i),
    .pkt_byte_req_o(pkt_byte_req_o), .pkt_byte_idx_o(pkt_byte_idx_o), .pkt_busy_o(pkt_busy_o));
  hpl_host_model host (.clk_i(clk_i), .fast_i(fast_baud_i), .tx_i(tx_o), .rx_o(rx_w));
  // ==========
  // Counts good packets, keeps payload, cuts a hang short
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cmd_stb_o === 1'b1) n_cmd <= n_cmd + 1;
    if (cmd_byte_stb_o === 1'b1) pay_q.push_back(cmd_byte_o);
    if (cyc == 120000) begin
      mismatches++;
      $display("[ERR] %0t timeout", $time);
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    if (mismatches == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One edge between calls, then wait out the last character of the previous packet
  task automatic go(input logic [1:0] c, input logic [5:0] k, input logic [4:0] l);
    @(negedge clk_i);
    for (int i = 0; i < 3000 && pkt_busy_o !== 1'b0; i++) @(negedge clk_i);
    pkt_cls_i = c;
    pkt_code_i = k;
    pkt_len_i = l;
    pkt_go_i = 1'b1;
    @(negedge clk_i);
    pkt_go_i = 1'b0;
  endtask
  // Waiting for each accepted command strobe first keeps the host from overrunning the link
  task automatic wait_n(input int n);
    for (int i = 0; i < 30000 && n_cmd < n; i++) @(negedge clk_i);
    chk(n_cmd, n);
  endtask
  // Host resends after a silent deadline and gives up after three tries
  task automatic send_retry(input logic [7:0] t, input int n, input logic bad);
    int tries;
    tries = 0;
    while (n_cmd < n && tries < 3) begin
      host.send_pkt(t, 8'h00, 8'h00, bad && tries == 0);
      for (int i = 0; i < DL && n_cmd < n; i++) @(negedge clk_i);
      tries++;
    end
    chk(n_cmd, n);
    chk(tries, bad ? 2 : 1);
  endtask
  // Sends one packet out and judges the frame the host saw
  task automatic reply(input logic [1:0] c, input logic [5:0] k, input logic [4:0] l);
    logic [15:0] crc;
    host.rxq.delete();
    go(c, k, l);
    for (int i = 0; i < 25000 && host.rxq.size() < l + 4; i++) @(negedge clk_i);
    crc = host.crc_upd(host.crc_upd(16'hffff, {c, k}), {3'b000, l});
    if (l != 5'h00) crc = host.crc_upd(crc, pkt_byte_i);
    chk(host.rxq.size(), l + 4);
    chk(host.rxq[0], {c, k});
    chk(host.rxq[1], l);
    if (l != 5'h00) chk(host.rxq[2], pkt_byte_i);
    chk(host.rxq[2 + l], crc[7:0]);
    chk(host.rxq[3 + l], crc[15:8]);
  endtask
  // Start bit width at the reset rate, then a reset in mid-frame
  task automatic t_slow();
    int n;
    n = 0;
    go(2'b01, 6'h01, 5'h00);
    for (int i = 0; i < 50 && tx_o !== 1'b0; i++) @(negedge clk_i);
    while (tx_o === 1'b0 && n < 2000) begin
      @(negedge clk_i);
      n++;
    end
    chk(n >= 1300 && n <= 1304, 1);
    rstn_i = 1'b0;
    repeat (3) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (4) @(negedge clk_i);
    chk({tx_o, pkt_busy_o}, 2'b10);
    fast_baud_i = 1'b1;
    repeat (2000) @(negedge clk_i);
  endtask
  // Good command, report interleaved, answer, refused command class
  task automatic t_cmd_reply();
    host.send_pkt(8'h05, 8'h01, 8'ha5, 1'b0);
    wait_n(1);
    chk({cmd_code_o, cmd_len_o, pay_q[0], pend_o}, {6'h05, 5'h01, 8'ha5, 1'b1});
    reply(2'b10, 6'h02, 5'h00);
    chk(pend_o, 1'b1);
    reply(2'b01, 6'h05, 5'h01);
    chk(pend_o, 1'b0);
    go(2'b00, 6'h05, 5'h00);
    chk(pkt_busy_o, 1'b0);
  endtask
  // Bad check value, over-long length, stalled partial, late flag
  task automatic t_faults();
    send_retry(8'h09, 2, 1'b1);
    chk(cmd_code_o, 6'h09);
    host.send_byte(8'h07);
    host.send_byte(8'h13);
    // Partial packet: two payload bytes promised, one sent, then silence
    host.send_byte(8'h07);
    host.send_byte(8'h02);
    host.send_byte(8'haa);
    repeat (DL - 3000) @(negedge clk_i);
    chk({late_o, n_cmd[1:0]}, 3'b110);
    send_retry(8'h0b, 3, 1'b0);
    chk({cmd_code_o, late_o}, {6'h0b, 1'b0});
    reply(2'b11, 6'h0b, 5'h00);
    chk(pend_o, 1'b0);
  endtask
  initial begin
    repeat (12) @(negedge clk_i);
    rstn_i = 1'b1;
    repeat (4) @(negedge clk_i);
    t_slow();
    t_cmd_reply();
    t_faults();
    complete_run();
  end
endmodule // tb_hpl_link
bind hpl_link hpl_link_chk #(.DEADLINE_CYC(DEADLINE_CYC)) u_chk (
  .clk_i(clk_i), .rstn_i(rstn_i), .tx_o(tx_o), .cmd_stb_o(cmd_stb_o), .cmd_code_o(cmd_code_o),
  .cmd_len_o(cmd_len_o), .pend_o(pend_o), .late_o(late_o), .pkt_go_i(pkt_go_i),
  .pkt_cls_i(pkt_cls_i), .pkt_code_i(pkt_code_i), .pkt_busy_o(pkt_busy_o),
  .pkt_byte_req_o(pkt_byte_req_o), .pkt_byte_idx_o(pkt_byte_idx_o));
